/* verification/sid_host_model.sv */
`timescale 1ns/10ps
module sid_host_model (
	input  wire logic               clk_i,
	input  wire logic               sda_oe_i,
	output sid_pkg::sid_pins_t      pins_o
);
	import sid_pkg::*;
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	// Pull-up wins unless a party pulls low
	assign pins_o = {scl_q, sda_q & ~sda_oe_i};
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Also a repeated start when SCL is low; SCL rises only after the device
	// has had time to let go of an acknowledge, else a false STOP appears
	task automatic start();
		tick(2);
		sda_q <= 1'b1;
		tick(2);
		scl_q <= 1'b1;
		tick(4);
		sda_q <= 1'b0;
		tick(4);
		scl_q <= 1'b0;
	endtask
	// SDA moves only in the low phase, one pulse per bit
	task automatic bit_x(input logic b, output logic r);
		tick(2);
		sda_q <= b;
		tick(2);
		scl_q <= 1'b1;
		tick(2);
		r = pins_o.sda;
		tick(2);
		scl_q <= 1'b0;
	endtask
	// MSB first, ninth pulse for the acknowledge
	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
		bit_x(mack, ack);
	endtask
	task automatic stop();
		tick(2);
		sda_q <= 1'b0;
		tick(2);
		scl_q <= 1'b1;
		tick(4);
		sda_q <= 1'b1;
		tick(4);
	endtask
endmodule

/* verification/sid_i2c_checker.sv */
`timescale 1ns/10ps
module sid_i2c_checker #(
	parameter int TIMEOUT_CYC = 200
) (
	input wire logic               clk_i,
	input wire logic               srst_i,
	input wire sid_pkg::sid_pins_t pins_i,
	input wire logic               sda_o,
	input wire logic               sda_oe_o,
	input wire logic               bus_mode_o,
	input wire logic [3:0]         ptr_o,
	input wire logic               busy_o
);
	import sid_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence s_start;
		pins_i.scl && $past(pins_i.scl) && $fell(pins_i.sda);
	endsequence
	sequence s_stop;
		pins_i.scl && $past(pins_i.scl) && $rose(pins_i.sda);
	endsequence
	logic [15:0] lo_q;
	// Cycles with SCL held low
	always_ff @(posedge clk_i) lo_q <= pins_i.scl ? 16'h0 : lo_q + 16'h1;
	a_open_drain: assert property (sda_o == 1'b0)
		else $error("sda_o high");
	a_reset_vals: assert property (disable iff (1'b0) srst_i |=> !sda_oe_o && bus_mode_o && !busy_o && ptr_o == 4'h0)
		else $error("reset values");
	a_ptr_range: assert property (ptr_o <= 4'h8)
		else $error("ptr out of map");
	a_ptr_moves: assert property (!$stable(ptr_o) |-> $past(busy_o))
		else $error("ptr moved idle");
	a_drive_low: assert property ($rose(sda_oe_o) |-> !pins_i.scl)
		else $error("drive with scl high");
	a_hold_high: assert property (pins_i.scl && $past(pins_i.scl) |-> $stable(sda_oe_o))
		else $error("sda moved scl high");
	a_start_busy: assert property (s_start |-> ##[1:5] busy_o)
		else $error("start missed");
	a_stop_idle: assert property (s_stop |-> ##[1:5] (!busy_o && !sda_oe_o))
		else $error("stop missed");
	// Margin covers the two-flop sync lag
	a_timeout_idle: assert property (bus_mode_o && lo_q == 16'(TIMEOUT_CYC + 6) |-> !busy_o && !sda_oe_o)
		else $error("no timeout");
endmodule
bind sid_i2c_slave sid_i2c_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.clk_i, .srst_i, .pins_i,
	.sda_o, .sda_oe_o, .bus_mode_o, .ptr_o, .busy_o);

/* verification/test_sid_i2c_slave.sv */
`timescale 1ns/10ps
module test_sid_i2c_slave;
	import sid_pkg::*;
	localparam logic [6:0]  ADR = 7'h50;
	localparam logic [7:0]  FAM = 8'hA5;
	localparam logic [47:0] SER = 48'h0123_4567_89AB;
	logic             clk_i = 1'b0;
	logic             srst_i = 1'b1;
	sid_pins_t        pins;
	logic             sda_o, sda_oe_o, bus_mode_o, busy_o, ak, bm;
	logic [3:0]       ptr_o, ep;
	logic [7:0]       rx, p;
	int               n_mismatch = 0;
	int               samples_checked = 0;
	always #10 clk_i = ~clk_i;
	sid_i2c_slave #(.SLAVE_ADDR(ADR), .FAMILY_CODE(FAM), .SERIAL_NUM(SER), .TIMEOUT_CYC(200)) dut (.clk_i,
		.srst_i, .pins_i(pins), .sda_o, .sda_oe_o, .bus_mode_o, .ptr_o, .busy_o);
	sid_host_model m (.clk_i, .sda_oe_i(sda_oe_o), .pins_o(pins));
	// Check byte worked out a byte at a time, reflected x^8 + x^5 + x^4 + 1
	function automatic logic [7:0] exp_crc();
		logic [55:0] d;
		logic [7:0]  c;
		d = {SER, FAM};
		c = 8'h00;
		for (int k = 0; k < 7; k++) begin
			c = c ^ d[8 * k +: 8];
			for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ 8'h8C) : (c >> 1);
		end
		return c;
	endfunction
	function automatic logic [7:0] exp_byte(input logic [3:0] a);
		if (a == 4'h0) return FAM;
		if (a == 4'h7) return exp_crc();
		if (a == 4'h8) return {7'h00, bm};
		return SER[8 * (a - 1) +: 8];
	endfunction
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic sel(input logic [6:0] a, input logic r);
		m.start();
		m.xfer({a, r}, 1'b1, rx, ak);
	endtask
	task automatic setp(input logic [7:0] v);
		sel(ADR, 1'b0);
		chk("adr_ack", 8'h00, {7'h0, ak});
		m.xfer(v, 1'b1, rx, ak);
		chk("ptr_ack", {7'h0, v > 8'h08}, {7'h0, ak});
	endtask
	task automatic wr(input logic [7:0] v);
		m.xfer(v, 1'b1, rx, ak);
		chk("wr_ack", {7'h0, ep != 4'h8}, {7'h0, ak});
		if (ep == 4'h8) bm = v[0];
		chk("wr_mode", {7'h0, bm}, {7'h0, bus_mode_o});
		ep = (ep == 4'h8) ? 4'h0 : ep + 4'h1;
		chk("wr_ptr", {4'h0, ep}, {4'h0, ptr_o});
	endtask
	task automatic rdn(input int n);
		sel(ADR, 1'b1);
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hFF, i == n - 1, rx, ak);
			chk("rd_data", exp_byte(ep), rx);
			ep = (ep == 4'h8) ? 4'h0 : ep + 4'h1;
		end
		m.tick(4);
		chk("rd_ptr", {4'h0, ep}, {4'h0, ptr_o});
		chk("release", 8'h00, {7'h0, sda_oe_o});
		m.stop();
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hbd1d));
		bm = 1'b1;
		ep = 4'h0;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("rst_ptr", 8'h00, {4'h0, ptr_o});
		chk("rst_mode", 8'h01, {7'h0, bus_mode_o});
		rdn(10);
		sel(ADR ^ 7'(1 + $urandom_range(0, 125)), 1'b0);
		chk("bad_adr", 8'h01, {7'h0, ak});
		m.stop();
		for (int k = 0; k < 8; k++) begin
			p = (k < 2) ? 8'(9 + $urandom_range(0, 246)) : (k == 2) ? 8'h08 : 8'($urandom_range(0, 8));
			setp(p);
			if (p <= 8'h08) begin
				ep = p[3:0];
				wr(8'($urandom));
				rdn(2);
			end else begin
				m.stop();
				chk("ptr_kept", {4'h0, ep}, {4'h0, ptr_o});
			end
		end
		// Plain two-wire mode: the same stall must not end the transfer
		setp(8'h08);
		ep = 4'h8;
		wr(8'h00);
		repeat (260) @(posedge clk_i);
		chk("no_timeout", 8'h01, {7'h0, busy_o});
		setp(8'h08);
		ep = 4'h8;
		wr(8'h01);
		setp(8'h03);
		ep = 4'h3;
		// Hold SCL low long enough to trip the bus timeout
		repeat (260) @(posedge clk_i);
		chk("to_busy", 8'h00, {7'h0, busy_o});
		chk("to_ptr", 8'h03, {4'h0, ptr_o});
		m.stop();
		rdn(1);
		final_report();
	end
	initial begin
		// Nearly four times the length of a clean run
		#400000;
		n_mismatch++;
		final_report();
	end
endmodule

/* verilog/sid_consts.svh */
`ifndef SID_CONSTS_SVH
`define SID_CONSTS_SVH

// Memory map
`define SID_PTR_RST       4'h0
`define SID_MEM_FIRST     4'h0
`define SID_MEM_LAST      4'h8
`define SID_REG_CTRL      4'h8
`define SID_ROM_BYTES     8

// Control byte layout
`define SID_CM_BIT        0
`define SID_CM_RST        1'b1

// Clock and bus timeout
`define SID_CLK_HZ        50000000
`define SID_TIMEOUT_MS    25
`define SID_TIMEOUT_CYC   (`SID_TIMEOUT_MS * (`SID_CLK_HZ / 1000))

// Checksum polynomial x^8 + x^5 + x^4 + 1, bit-reversed for LSB-first shifting
`define SID_CRC_POLY      8'h8C

`endif

/* verilog/sid_i2c_slave.sv */
`timescale 1ns/10ps
`include "sid_consts.svh"
// Notes on behaviour
// RQ1: Address byte LSB: 0 write, 1 read.
// RQ2: Bytes MSB first, ninth clock is acknowledge.
// RQ3: START/STOP are SDA edges with SCL high.
// RQ4: SDA change with SCL high is START/STOP.
// RQ5: Repeated START restarts like normal START.
// RQ6: Receiver samples SDA on SCL rising edge.
// RQ7: Transmit bits change on SCL falling edge.
// RQ8: Master generates every SCL pulse.
// RQ9: Acknowledge holds SDA low through high phase.
// RQ10: Matching slave address is always acknowledged.
// RQ11: Refused bytes are not acknowledged, SDA released.
// RQ12: After refusal master restarts or stops.
// RQ13: Master NACK ends read; release SDA.
// RQ14: First written byte loads address pointer.
// RQ15: Acknowledge pointer bytes 00h to 08h only.
// RQ16: Writes to read-only bytes discarded, not acknowledged.
// RQ17: Write advances pointer per byte, wraps 08h.
// RQ18: Read starts at pointer, advances, wraps 08h.
// RQ19: Pointer resets to 00h.
// RQ20: Bus timeout leaves pointer unchanged.
// RQ21: SCL input only; SDA open-drain low.
// RQ22: Control byte: bit 0 mode, rest zero.
// RQ23: Mode 1: stuck bus times out, acts STOP.
// RQ24: Only fixed slave address answered; others ignored.

module sid_i2c_slave #(
	parameter logic [6:0]  SLAVE_ADDR  = 7'h50,
	// Arbitrary identification values, not tied to any real part
	parameter logic [7:0]  FAMILY_CODE = 8'hA5,
	parameter logic [47:0] SERIAL_NUM  = 48'h0123_4567_89AB,
	parameter int          TIMEOUT_CYC = `SID_TIMEOUT_CYC
) (
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire sid_pkg::sid_pins_t pins_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	output logic                   bus_mode_o,
	output logic [3:0]             ptr_o,
	output logic                   busy_o
);
	import sid_pkg::*;

	localparam int TW = $clog2(TIMEOUT_CYC + 1);

	// The one-shot compare below needs a limit above one
	generate
		if (TIMEOUT_CYC < 2) begin : g_bad_timeout
			$error("TIMEOUT_CYC must be at least 2");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Identification bytes and their checksum

	function automatic logic [7:0] sid_crc8(input logic [55:0] d);
		logic [7:0] c;
		logic       fb;
		c  = 8'h00;
		fb = 1'b0;
		for (int i = 0; i < 56; i++) begin
			fb = c[0] ^ d[i];
			c  = c >> 1;
			if (fb) begin
				c = c ^ `SID_CRC_POLY;
			end
		end
		return c;
	endfunction

	localparam logic [55:0] ID_BODY = {SERIAL_NUM, FAMILY_CODE};
	localparam logic [63:0] ID_ROM  = {sid_crc8(ID_BODY), ID_BODY};

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] prev_q;
	logic [1:0] pins_v;

	assign pins_v = pins_i;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					meta_q[gi] <= 1'b1;
					sync_q[gi] <= 1'b1;
					prev_q[gi] <= 1'b1;
				end else begin
					meta_q[gi] <= pins_v[gi];
					sync_q[gi] <= meta_q[gi];
					prev_q[gi] <= sync_q[gi];
				end
			end
		end
	endgenerate

	logic scl_s;
	logic sda_s;
	logic scl_p;
	logic sda_p;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign scl_s    = sync_q[1];
	assign sda_s    = sync_q[0];
	assign scl_p    = prev_q[1];
	assign sda_p    = prev_q[0];
	assign scl_rise = scl_s & ~scl_p; // [RQ6]
	assign scl_fall = ~scl_s & scl_p; // [RQ7]
	// SDA moving while SCL holds high is never data
	assign start_det = scl_s & scl_p & sda_p & ~sda_s; // [RQ3] [RQ4]
	assign stop_det  = scl_s & scl_p & ~sda_p & sda_s; // [RQ3] [RQ4]

	////////////////////////////////////////////////////////////////////////
	// Bus timeout

	logic          cm_q;
	logic [TW-1:0] scl_cnt_q;
	logic [TW-1:0] sda_cnt_q;
	logic          tout;
	logic          scl_edge;

	assign scl_edge = scl_s ^ scl_p;

	// One pulse when a counter reaches the limit, so a START after a
	// long idle with SCL high is not swallowed by a standing timeout
	assign tout = cm_q & ((scl_cnt_q == TW'(TIMEOUT_CYC - 1) & ~scl_edge) |
			(sda_cnt_q == TW'(TIMEOUT_CYC - 1) & ~sda_s)); // [RQ23]

	// Both counters stop at the limit, so a stuck bus trips only once
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			scl_cnt_q <= '0;
			sda_cnt_q <= '0;
		end else begin
			if (scl_edge) begin
				scl_cnt_q <= '0;
			end else if (scl_cnt_q != TW'(TIMEOUT_CYC)) begin
				scl_cnt_q <= scl_cnt_q + TW'(1);
			end
			if (sda_s) begin
				sda_cnt_q <= '0;
			end else if (sda_cnt_q != TW'(TIMEOUT_CYC)) begin
				sda_cnt_q <= sda_cnt_q + TW'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte decisions

	sid_state_t st_q;
	sid_phase_t ph_q;
	logic [2:0] bitc_q;
	logic [7:0] sh_q;
	logic       ack_q;
	logic       rw_q;
	logic       sda_low_q;
	logic [3:0] ptr_q;

	logic       evt_ok;
	logic [7:0] byte_in;
	logic       addr_hit;
	logic       ptr_ok;
	logic       rx_done;
	logic       rx_ack;
	logic       ptr_load;
	logic       wr_done;
	logic       rd_load;
	logic [7:0] mem_byte;

	assign evt_ok   = ~start_det & ~stop_det & ~tout;
	assign byte_in  = {sh_q[6:0], sda_s}; // [RQ2]
	assign addr_hit = (byte_in[7:1] == SLAVE_ADDR); // [RQ24]
	assign ptr_ok   = (byte_in <= {4'h0, `SID_MEM_LAST}); // [RQ15]
	assign rx_done  = evt_ok & (st_q == SID_RX) & scl_rise & (bitc_q == 3'd7);

	always_comb begin
		case (ph_q)
			SID_PH_ADDR: rx_ack = addr_hit; // [RQ10] [RQ24]
			SID_PH_PTR:  rx_ack = ptr_ok; // [RQ15]
			default:     rx_ack = (ptr_q == `SID_REG_CTRL); // [RQ16]
		endcase
	end

	assign ptr_load = rx_done & (ph_q == SID_PH_PTR) & ptr_ok; // [RQ14]
	assign wr_done  = rx_done & (ph_q == SID_PH_DATA);
	// A read moves the pointer when the byte is loaded, before it is sent
	assign rd_load  = evt_ok & scl_fall & (((st_q == SID_ACK) & (ph_q == SID_PH_ADDR) & rw_q) |
			((st_q == SID_MACK) & ack_q)); // [RQ18]

	// Locations past the control byte never occur: the pointer stays in 0..8
	assign mem_byte = (ptr_q == `SID_REG_CTRL) ? {7'h00, cm_q} : ID_ROM[ptr_q[2:0]*8 +: 8]; // [RQ22]

	////////////////////////////////////////////////////////////////////////
	// Protocol state machine and SDA driver

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_q      <= SID_IDLE;
			ph_q      <= SID_PH_ADDR;
			bitc_q    <= 3'd0;
			sh_q      <= 8'h00;
			ack_q     <= 1'b0;
			rw_q      <= 1'b0;
			sda_low_q <= 1'b0;
		end else if (start_det) begin
			// Repeated START needs no STOP before it
			st_q      <= SID_RX; // [RQ5]
			ph_q      <= SID_PH_ADDR;
			bitc_q    <= 3'd0;
			sda_low_q <= 1'b0;
		end else if (stop_det | tout) begin
			st_q      <= SID_IDLE; // [RQ23]
			sda_low_q <= 1'b0;
		end else begin
			case (st_q)
				SID_RX: begin
					if (scl_rise) begin
						sh_q   <= byte_in; // [RQ6]
						bitc_q <= bitc_q + 3'd1;
						if (bitc_q == 3'd7) begin
							ack_q <= rx_ack;
							if (ph_q == SID_PH_ADDR) begin
								rw_q <= byte_in[0]; // [RQ1]
							end
							// Foreign address: stay off the bus until next START
							st_q <= (ph_q == SID_PH_ADDR && !addr_hit) ? SID_IDLE : SID_ACKW; // [RQ24]
						end
					end
				end
				SID_ACKW: begin
					if (scl_fall) begin
						sda_low_q <= ack_q; // [RQ9] [RQ11]
						st_q      <= SID_ACK;
					end
				end
				SID_ACK: begin
					if (scl_fall) begin
						bitc_q <= 3'd0;
						if (!ack_q && ph_q != SID_PH_DATA) begin
							sda_low_q <= 1'b0; // [RQ11]
							st_q      <= SID_IDLE;
						end else if (ph_q == SID_PH_ADDR && rw_q) begin
							sh_q      <= mem_byte;
							sda_low_q <= ~mem_byte[7]; // [RQ7]
							st_q      <= SID_TX;
						end else begin
							sda_low_q <= 1'b0;
							st_q      <= SID_RX;
							ph_q      <= (ph_q == SID_PH_ADDR) ? SID_PH_PTR : SID_PH_DATA;
						end
					end
				end
				SID_TX: begin
					if (scl_fall) begin
						if (bitc_q == 3'd7) begin
							sda_low_q <= 1'b0;
							st_q      <= SID_MACK;
						end else begin
							sh_q      <= {sh_q[6:0], 1'b0};
							sda_low_q <= ~sh_q[6]; // [RQ2] [RQ7]
							bitc_q    <= bitc_q + 3'd1;
						end
					end
				end
				SID_MACK: begin
					if (scl_rise) begin
						ack_q <= ~sda_s;
					end else if (scl_fall) begin
						bitc_q <= 3'd0;
						if (ack_q) begin
							sh_q      <= mem_byte;
							sda_low_q <= ~mem_byte[7];
							st_q      <= SID_TX;
						end else begin
							// Master declined more data: let it issue STOP
							sda_low_q <= 1'b0; // [RQ13]
							st_q      <= SID_IDLE;
						end
					end
				end
				default: begin
					sda_low_q <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address pointer

	// Only a reset clears it; a bus timeout leaves it alone so that the
	// host can carry on from where it stopped
	always_ff @(posedge clk_i) begin // [RQ20]
		if (srst_i) begin
			ptr_q <= `SID_PTR_RST; // [RQ19]
		end else if (ptr_load) begin
			ptr_q <= byte_in[3:0]; // [RQ14]
		end else if (wr_done | rd_load) begin
			if (ptr_q == `SID_MEM_LAST) begin
				ptr_q <= `SID_MEM_FIRST; // [RQ17] [RQ18]
			end else begin
				ptr_q <= ptr_q + 4'h1; // [RQ17] [RQ18]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control byte

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cm_q <= `SID_CM_RST; // [RQ22]
		end else if (wr_done && ptr_q == `SID_REG_CTRL) begin
			// Upper bits are not stored and read back as zero
			cm_q <= byte_in[`SID_CM_BIT]; // [RQ22]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Open drain: the pad only ever pulls low, SCL is never driven
	assign sda_o      = 1'b0; // [RQ21]
	assign sda_oe_o   = sda_low_q; // [RQ21]
	assign bus_mode_o = cm_q;
	assign ptr_o      = ptr_q;
	// Busy also covers a byte meant for another device, up to its last bit
	assign busy_o     = (st_q != SID_IDLE);

endmodule

/* verilog/sid_pkg.sv */
package sid_pkg;

	typedef enum logic [2:0] {
		SID_IDLE,
		SID_RX,
		SID_ACKW,
		SID_ACK,
		SID_TX,
		SID_MACK
	} sid_state_t;

	typedef enum logic [1:0] {
		SID_PH_ADDR,
		SID_PH_PTR,
		SID_PH_DATA
	} sid_phase_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} sid_pins_t;

endpackage
